// ===== logic/apfs_bit_reg.sv
// Eight-bit control register with byte and single-bit writes
`include "apfs_defines.svh"

module apfs_bit_reg #(
   parameter logic [7:0] RST_VAL = 8'hFF,
   parameter logic [7:0] IMPL    = 8'hFF,
   parameter logic [7:0] FILL    = 8'hFF
) (
   input  wire logic       core_clk_in,
   input  wire logic       resetn_in,
   input  wire logic       wr_in,
   input  wire logic       bit_mode_in,
   input  wire logic [2:0] bit_idx_in,
   input  wire logic       bit_val_in,
   input  wire logic [7:0] wdata_in,
   output logic      [7:0] q_out
);

   logic [7:0] value_reg;
   logic [7:0] value_next;
   logic [7:0] raw;

   // Absent bits are forced to the fill value so they never move
   always_comb begin
      raw = value_reg;
      if (wr_in) begin
         if (bit_mode_in) begin
            raw[bit_idx_in] = bit_val_in;
         end else begin
            raw = wdata_in;
         end
      end
      value_next = (raw & IMPL) | (FILL & ~IMPL);
   end

   // Storage
   always_ff @(posedge core_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         value_reg <= (RST_VAL & IMPL) | (FILL & ~IMPL);
      end else begin
         value_reg <= value_next;
      end
   end

   assign q_out = value_reg;

endmodule

// ===== logic/apfs_defines.svh
// Offsets, field positions and reset values of the analog pin selector
`ifndef APFS_DEFINES_SVH
`define APFS_DEFINES_SVH

// Register indices; the byte address is four times the index
`define APFS_IDX_DIR2      16'hFF22
`define APFS_IDX_DIR7      16'hFF27
`define APFS_IDX_SEL_LO    16'hFF2E
`define APFS_IDX_SEL_HI    16'hFF2F
`define APFS_IDX_CHAN      16'hFF0E
`define APFS_IDX_AMP_CTRL  16'hFF40
`define APFS_IDX_CMP_EN    16'hFF41
`define APFS_IDX_STATUS    16'hFF42

// Reset values
`define APFS_RST_DIR       8'hFF
`define APFS_RST_SEL       8'h00
`define APFS_RST_CHAN      8'h00
`define APFS_RST_CTRL      8'h00

// Implemented direction bits per variant
`define APFS_IMPL2_FULL    8'hFF
`define APFS_IMPL2_MID     8'h3F
`define APFS_IMPL2_RED     8'h3D
`define APFS_IMPL7_FULL    8'h01
`define APFS_IMPL_NONE     8'h00

// Field positions
`define APFS_AMP_EN_BIT    7
`define APFS_GAIN_EN_BIT   6
`define APFS_CH_GAIN_BIT   6
`define APFS_CH_REF_BIT    7
`define APFS_CH_CODE_MSB   3
`define APFS_BITWR_FLAG    16
`define APFS_BITWR_IDX_LSB 8
`define APFS_BITWR_IDX_MSB 10
`define APFS_ST_PROHIB     0
`define APFS_ST_CONV_GAIN  1
`define APFS_ST_CONV_REF   2

// Pin roles
`define APFS_PIN_AMP_A     0
`define APFS_PIN_AMP_B     2
`define APFS_PIN_AMP_OUT   1
`define APFS_PIN_CMP_FIRST 3
`define APFS_CHAN_LAST     4'h8

`endif

// ===== logic/apfs_pin_mux.sv
// Function selector for the shared analog and digital pins of ports 2, 7
//
// Added by the designer: register access over APB.
`include "apfs_defines.svh"

// Notes on behaviour
// RULE1 - Port 2 direction: 0 drives, 1 inputs
// RULE2 - Port 7 bit 0 same direction coding
// RULE3 - Reset loads both direction registers ones
// RULE4 - Analog input only while direction is input
// RULE5 - Output latch ignored for analog pins
// RULE6 - Direction registers take byte or bit writes
// RULE7 - Software writes ones to absent bits
// RULE8 - Digital pin unselected acts as port I/O
// RULE9 - Software avoids digital channel, analog output
// RULE10 - Analog input converted only when selected
// RULE11 - Amplifier enable routes pins 0, 2
// RULE12 - Comparator enable routes pins 3 to 5
// RULE13 - Gain enable makes pin 1 gain input
// RULE14 - Amplifier enable puts output on pin 1
// RULE15 - No amplifier while pin 1 digital
// RULE16 - Select bit: 0 analog, 1 digital
// RULE17 - Channel code picks pin, gain or reference
// RULE18 - Absent direction bits read one, ignore writes
module apfs_pin_mux #(
   parameter apfs_pkg::apfs_variant_t VARIANT = apfs_pkg::apfs_var_full,
   parameter int                      ADDR_W  = 18
) (
   input  wire logic              core_clk_in,
   input  wire logic              resetn_in,
   input  wire logic              psel_in,
   input  wire logic              penable_in,
   input  wire logic              pwrite_in,
   input  wire logic [ADDR_W-1:0] paddr_in,
   input  wire logic [31:0]       pwdata_in,
   input  wire logic [3:0]        pstrb_in,
   output logic      [31:0]       prdata_out,
   output logic                   pready_out,
   output logic                   pslverr_out,
   input  wire logic [8:0]        pad_in,
   input  wire logic [8:0]        out_latch_in,
   output logic      [8:0]        pad_out,
   output logic      [8:0]        pad_oe_n_out,
   output logic      [8:0]        dig_in_out,
   output logic      [8:0]        conv_pin_out,
   output logic                   conv_gain_out,
   output logic                   conv_ref_out,
   output logic      [1:0]        amp_in_out,
   output logic                   amp_out_pin_out,
   output logic                   gain_in_out,
   output logic      [2:0]        cmp_pos_out,
   output logic                   prohibited_out
);

   // ***********************************************************
   // Register file
   // ***********************************************************
   localparam logic [7:0] DIR2_IMPL =
      (VARIANT == apfs_pkg::apfs_var_reduced) ? `APFS_IMPL2_RED :
      (VARIANT == apfs_pkg::apfs_var_mid)     ? `APFS_IMPL2_MID :
                                                `APFS_IMPL2_FULL;
   localparam logic [7:0] DIR7_IMPL =
      (VARIANT == apfs_pkg::apfs_var_full) ? `APFS_IMPL7_FULL :
                                             `APFS_IMPL_NONE;

   apfs_pkg::apfs_bus_st_t st_reg;
   apfs_pkg::apfs_bus_st_t st_next;
   logic [31:0] prdata_reg;
   logic [31:0] prdata_next;
   logic        pready_reg;
   logic        pready_next;
   logic        pslverr_reg;
   logic        pslverr_next;
   logic [15:0] idx;
   logic        aligned;
   logic        hit;
   logic        wr_go;
   logic        bit_mode;
   logic [2:0]  bit_idx;
   logic [7:0]  dir2_q;
   logic [7:0] dir7_q;
   logic [7:0]  sel_lo_q;
   logic [7:0]  sel_hi_q;
   logic [7:0]  chan_reg;
   logic [7:0]  chan_next;
   logic [7:0]  amp_ctrl_reg;
   logic [7:0]  amp_ctrl_next;
   logic [7:0]  cmp_en_reg;
   logic [7:0]  cmp_en_next;
   logic [7:0]  status;

   // Address decode; a misaligned address is treated as unmapped
   assign idx     = 16'(paddr_in[ADDR_W-1:2]);
   assign aligned = (paddr_in[1:0] == 2'h0);
   assign hit     = aligned && (idx == `APFS_IDX_DIR2 ||
                    idx == `APFS_IDX_DIR7 || idx == `APFS_IDX_SEL_LO ||
                    idx == `APFS_IDX_SEL_HI || idx == `APFS_IDX_CHAN ||
                    idx == `APFS_IDX_AMP_CTRL ||
                    idx == `APFS_IDX_CMP_EN || idx == `APFS_IDX_STATUS);
   // A write lands only on the edge that completes the access phase
   assign wr_go    = (st_reg == apfs_pkg::apfs_st_access) && psel_in &&
                     penable_in && pwrite_in && pready_reg && hit &&
                     pstrb_in[0];
   assign bit_mode = pwdata_in[`APFS_BITWR_FLAG];
   assign bit_idx  = pwdata_in[`APFS_BITWR_IDX_MSB:`APFS_BITWR_IDX_LSB];
   assign status   = {5'h00, conv_ref_out, conv_gain_out, prohibited_out};

   // Zero-wait answer: ready rises with the first access cycle
   always_comb begin
      st_next      = st_reg;
      pready_next  = 1'b0;
      pslverr_next = 1'b0;
      prdata_next  = prdata_reg;
      unique case (st_reg)
         apfs_pkg::apfs_st_idle: begin
            if (psel_in && !penable_in) begin
               st_next      = apfs_pkg::apfs_st_access;
               pready_next  = 1'b1;
               pslverr_next = !hit;
               prdata_next  = 32'h0000_0000;
               if (!pwrite_in && aligned) begin
                  unique case (idx)
                     `APFS_IDX_DIR2:     prdata_next[7:0] = dir2_q;
                     `APFS_IDX_DIR7:     prdata_next[7:0] = dir7_q;
                     `APFS_IDX_SEL_LO:   prdata_next[7:0] = sel_lo_q;
                     `APFS_IDX_SEL_HI:   prdata_next[7:0] = sel_hi_q;
                     `APFS_IDX_CHAN:     prdata_next[7:0] = chan_reg;
                     `APFS_IDX_AMP_CTRL: prdata_next[7:0] = amp_ctrl_reg;
                     `APFS_IDX_CMP_EN:   prdata_next[7:0] = cmp_en_reg;
                     `APFS_IDX_STATUS:   prdata_next[7:0] = status;
                     default:            prdata_next      = 32'h0000_0000;
                  endcase
               end
            end
         end
         apfs_pkg::apfs_st_access: begin
            st_next = apfs_pkg::apfs_st_idle;
         end
      endcase
   end

   // Plain control registers, byte or single-bit written
   always_comb begin
      chan_next     = chan_reg;
      amp_ctrl_next = amp_ctrl_reg;
      cmp_en_next   = cmp_en_reg;
      if (wr_go && idx == `APFS_IDX_CHAN) begin
         if (bit_mode) chan_next[bit_idx] = pwdata_in[0];
         else chan_next = pwdata_in[7:0];
      end
      if (wr_go && idx == `APFS_IDX_AMP_CTRL) begin
         if (bit_mode) amp_ctrl_next[bit_idx] = pwdata_in[0];
         else amp_ctrl_next = pwdata_in[7:0];
      end
      if (wr_go && idx == `APFS_IDX_CMP_EN) begin
         if (bit_mode) cmp_en_next[bit_idx] = pwdata_in[0];
         else cmp_en_next = pwdata_in[7:0];
      end
   end

   always_ff @(posedge core_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         st_reg       <= apfs_pkg::apfs_st_idle;
         prdata_reg   <= 32'h0000_0000;
         pready_reg   <= 1'b0;
         pslverr_reg  <= 1'b0;
         chan_reg     <= `APFS_RST_CHAN;
         amp_ctrl_reg <= `APFS_RST_CTRL;
         cmp_en_reg   <= `APFS_RST_CTRL;
      end else begin
         st_reg       <= st_next;
         prdata_reg   <= prdata_next;
         pready_reg   <= pready_next;
         pslverr_reg  <= pslverr_next;
         chan_reg     <= chan_next;
         amp_ctrl_reg <= amp_ctrl_next;
         cmp_en_reg   <= cmp_en_next;
      end
   end

   assign prdata_out  = prdata_reg;
   assign pready_out  = pready_reg;
   assign pslverr_out = pslverr_reg;

   // Direction registers start all ones, absent bits pinned high
   apfs_bit_reg #(.RST_VAL(`APFS_RST_DIR), .IMPL(DIR2_IMPL),
      .FILL(`APFS_RST_DIR)) u_dir2 ( // [RULE3] [RULE6] [RULE18]
      .core_clk_in (core_clk_in),
      .resetn_in   (resetn_in),
      .wr_in       (wr_go && idx == `APFS_IDX_DIR2),
      .bit_mode_in (bit_mode),
      .bit_idx_in  (bit_idx),
      .bit_val_in  (pwdata_in[0]),
      .wdata_in    (pwdata_in[7:0]),
      .q_out       (dir2_q)
   );
   apfs_bit_reg #(.RST_VAL(`APFS_RST_DIR), .IMPL(DIR7_IMPL),
      .FILL(`APFS_RST_DIR)) u_dir7 ( // [RULE2] [RULE3] [RULE18]
      .core_clk_in (core_clk_in),
      .resetn_in   (resetn_in),
      .wr_in       (wr_go && idx == `APFS_IDX_DIR7),
      .bit_mode_in (bit_mode),
      .bit_idx_in  (bit_idx),
      .bit_val_in  (pwdata_in[0]),
      .wdata_in    (pwdata_in[7:0]),
      .q_out       (dir7_q)
   );
   // Selection registers; absent port 7 bits read as analog and ignore writes, all port 2 bits stay writable
   apfs_bit_reg #(.RST_VAL(`APFS_RST_SEL), .IMPL(`APFS_IMPL2_FULL),
      .FILL(`APFS_RST_SEL)) u_sel_lo (
      .core_clk_in (core_clk_in),
      .resetn_in   (resetn_in),
      .wr_in       (wr_go && idx == `APFS_IDX_SEL_LO),
      .bit_mode_in (bit_mode),
      .bit_idx_in  (bit_idx),
      .bit_val_in  (pwdata_in[0]),
      .wdata_in    (pwdata_in[7:0]),
      .q_out       (sel_lo_q)
   );
   apfs_bit_reg #(.RST_VAL(`APFS_RST_SEL), .IMPL(DIR7_IMPL),
      .FILL(`APFS_RST_SEL)) u_sel_hi (
      .core_clk_in (core_clk_in),
      .resetn_in   (resetn_in),
      .wr_in       (wr_go && idx == `APFS_IDX_SEL_HI),
      .bit_mode_in (bit_mode),
      .bit_idx_in  (bit_idx),
      .bit_val_in  (pwdata_in[0]),
      .wdata_in    (pwdata_in[7:0]),
      .q_out       (sel_hi_q)
   );

   // ***********************************************************
   // Pin function decode
   // ***********************************************************
   logic [8:0] dir_all;
   logic [8:0] dig_all;
   logic [8:0] chsel;
   logic       amp_en;
   logic       gain_en;
   logic       gain_pick;
   logic       ref_pick;
   logic [8:0] pad_s1_reg;
   logic [8:0] pad_s2_reg;
   logic [8:0] oe_n_next;
   logic [8:0] drive_next;
   logic [8:0] din_next;
   logic [8:0] conv_next;
   logic [1:0] amp_in_next;
   logic [2:0] cmp_next;
   logic       prohib_next;
   logic [8:0] oe_n_reg;
   logic [8:0] drive_reg;
   logic [8:0] din_reg;
   logic [8:0] conv_reg;
   logic [1:0] amp_in_reg;
   logic [2:0] cmp_reg;
   logic       prohib_reg;
   logic       amp_out_reg;
   logic       gain_in_reg;
   logic       conv_gain_reg;
   logic       conv_ref_reg;

   assign dir_all   = {dir7_q[0], dir2_q};
   assign dig_all   = {sel_hi_q[0], sel_lo_q}; // [RULE16]
   assign amp_en    = amp_ctrl_reg[`APFS_AMP_EN_BIT];
   assign gain_en   = amp_ctrl_reg[`APFS_GAIN_EN_BIT];
   assign ref_pick  = chan_reg[`APFS_CH_REF_BIT];
   assign gain_pick = !ref_pick && chan_reg[`APFS_CH_GAIN_BIT];
   // Codes above the last channel pick no pin
   assign chsel = (!ref_pick && !gain_pick &&
                  chan_reg[`APFS_CH_CODE_MSB:0] <= `APFS_CHAN_LAST) ?
                  9'(9'h001 << chan_reg[`APFS_CH_CODE_MSB:0]) :
                  9'h000; // [RULE17]

   // Pads come from outside; only the second stage is read
   always_ff @(posedge core_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         pad_s1_reg <= 9'h000;
         pad_s2_reg <= 9'h000;
      end else begin
         pad_s1_reg <= pad_in;
         pad_s2_reg <= pad_s1_reg;
      end
   end

   // Per-pin function; prohibited setups leave the pin undriven
   always_comb begin
      oe_n_next   = 9'h1FF;
      drive_next  = 9'h000;
      din_next    = 9'h000;
      conv_next   = 9'h000;
      prohib_next = 1'b0;
      for (int i = 0; i < 9; i++) begin
         if (dig_all[i]) begin
            if (chsel[i]) begin
               prohib_next = 1'b1; // [RULE9]
            end else if (i == `APFS_PIN_AMP_OUT && amp_en) begin
               prohib_next = 1'b1; // [RULE15]
            end else if (!dir_all[i]) begin
               oe_n_next[i]  = 1'b0; // [RULE1] [RULE2] [RULE8]
               drive_next[i] = out_latch_in[i];
            end else begin
               din_next[i] = pad_s2_reg[i]; // [RULE8]
            end
         end else if (dir_all[i]) begin
            // Latch never reaches an analog pin
            conv_next[i] = chsel[i]; // [RULE4] [RULE5] [RULE10]
         end else if (i == `APFS_PIN_AMP_OUT && (amp_en || gain_en)) begin
            conv_next[i] = chsel[i] && amp_en; // [RULE14]
         end else begin
            prohib_next = 1'b1; // [RULE4] [RULE9]
         end
      end
      amp_in_next[0] = !dig_all[`APFS_PIN_AMP_A] &&
                       dir_all[`APFS_PIN_AMP_A] && amp_en; // [RULE11]
      amp_in_next[1] = !dig_all[`APFS_PIN_AMP_B] &&
                       dir_all[`APFS_PIN_AMP_B] && amp_en; // [RULE11]
      // Pins 3, 4, 5 feed comparators 2, 0, 1
      cmp_next[0] = !dig_all[4] && dir_all[4] && cmp_en_reg[0];
      cmp_next[1] = !dig_all[5] && dir_all[5] && cmp_en_reg[1];
      cmp_next[2] = !dig_all[3] && dir_all[3] &&
                    cmp_en_reg[2]; // [RULE12]
   end

   // All pin-facing outputs leave from flops
   always_ff @(posedge core_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         oe_n_reg      <= 9'h1FF;
         drive_reg     <= 9'h000;
         din_reg       <= 9'h000;
         conv_reg      <= 9'h000;
         amp_in_reg    <= 2'h0;
         cmp_reg       <= 3'h0;
         prohib_reg    <= 1'b0;
         amp_out_reg   <= 1'b0;
         gain_in_reg   <= 1'b0;
         conv_gain_reg <= 1'b0;
         conv_ref_reg  <= 1'b0;
      end else begin
         oe_n_reg      <= oe_n_next;
         drive_reg     <= drive_next;
         din_reg       <= din_next;
         conv_reg      <= conv_next;
         amp_in_reg    <= amp_in_next;
         cmp_reg       <= cmp_next;
         prohib_reg    <= prohib_next;
         amp_out_reg   <= !dig_all[`APFS_PIN_AMP_OUT] && amp_en; // [RULE14]
         gain_in_reg   <= !dig_all[`APFS_PIN_AMP_OUT] &&
                          gain_en; // [RULE13] [RULE14]
         conv_gain_reg <= gain_pick && gain_en; // [RULE13]
         conv_ref_reg  <= ref_pick; // [RULE17]
      end
   end

   assign pad_oe_n_out    = oe_n_reg;
   assign pad_out         = drive_reg;
   assign dig_in_out      = din_reg;
   assign conv_pin_out    = conv_reg;
   assign amp_in_out      = amp_in_reg;
   assign cmp_pos_out     = cmp_reg;
   assign prohibited_out  = prohib_reg;
   assign amp_out_pin_out = amp_out_reg;
   assign gain_in_out     = gain_in_reg;
   assign conv_gain_out   = conv_gain_reg;
   assign conv_ref_out    = conv_ref_reg;

   // ***********************************************************
   // Checks
   // ***********************************************************
   default clocking cb @(posedge core_clk_in); endclocking
   default disable iff (!resetn_in);

   logic dir_written_reg;
   always_ff @(posedge core_clk_in or negedge resetn_in) begin
      if (!resetn_in) dir_written_reg <= 1'b0;
      else if (wr_go && idx == `APFS_IDX_DIR2) dir_written_reg <= 1'b1;
   end

   a_input_no_drive: assert property ( // [RULE1]
      dir_all[2] |=> pad_oe_n_out[2] && !pad_out[2])
      else $error("input-mode pin 2 is driven");
   a_p7_drive: assert property ( // [RULE2]
      dig_all[8] && !dir_all[8] && !chsel[8] |=>
      !pad_oe_n_out[8] && pad_out[8] == $past(out_latch_in[8]))
      else $error("port 7 output mode not driving latch");
   a_dir_reset_ones: assert property ( // [RULE3]
      !dir_written_reg |-> dir2_q == `APFS_RST_DIR)
      else $error("port 2 direction lost reset ones");
   a_analog_in_only: assert property ( // [RULE4]
      conv_pin_out[3] |-> $past(dir_all[3], 1))
      else $error("pin 3 converted in output mode");
   a_latch_ignored: assert property ( // [RULE5]
      !dig_all[4] |=> !pad_out[4] && pad_oe_n_out[4])
      else $error("analog pin 4 carries latch value");
   a_bit_write_keeps: assert property ( // [RULE6]
      wr_go && bit_mode && idx == `APFS_IDX_DIR2 && bit_idx == 3'h6 |=>
      dir2_q[5:0] == $past(dir2_q[5:0]) && dir2_q[7] == $past(dir2_q[7]))
      else $error("bit write disturbed other bits");
   a_digital_input: assert property ( // [RULE8]
      dig_all[5] && dir_all[5] && !chsel[5] |=>
      dig_in_out[5] == $past(pad_s2_reg[5]))
      else $error("digital input pin 5 not passed");
   a_convert_pick: assert property ( // [RULE10]
      !dig_all[3] && dir_all[3] |=> conv_pin_out[3] == $past(chsel[3]))
      else $error("analog pin 3 conversion mismatch");
   a_amp_route: assert property ( // [RULE11]
      !dig_all[0] && dir_all[0] && amp_en |=> amp_in_out[0])
      else $error("pin 0 not routed to amplifier");
   a_cmp_route: assert property ( // [RULE12]
      !dig_all[4] && dir_all[4] && cmp_en_reg[0] |=> cmp_pos_out[0])
      else $error("pin 4 not routed to comparator");
   a_gain_feed: assert property ( // [RULE13]
      !dig_all[1] && !amp_en && gain_en |=> gain_in_out && !amp_out_pin_out)
      else $error("pin 1 not feeding gain stage");
   a_absent_ones: assert property ( // [RULE18]
      dir7_q[7:1] == 7'h7F && (dir2_q | DIR2_IMPL) == 8'hFF)
      else $error("absent direction bit not one");

   c_read_back: cover property (
      psel_in && penable_in && pready_out && !pwrite_in && hit);
   c_converted: cover property (conv_pin_out != 9'h000);
   c_prohibited: cover property (prohibited_out);

endmodule

// ===== logic/apfs_pkg.sv
// Types shared by the analog pin selector files
package apfs_pkg;

   // Bus answer state, one-hot
   typedef enum logic [1:0] {
      apfs_st_idle   = 2'b01,
      apfs_st_access = 2'b10
   } apfs_bus_st_t;

   // Pin-count variant of the device
   typedef enum logic [1:0] {
      apfs_var_full    = 2'b00,
      apfs_var_mid     = 2'b01,
      apfs_var_reduced = 2'b10
   } apfs_variant_t;

endpackage

// ===== sim/tb_top.sv
// Self-checking bench for the analog pin function selector
`include "apfs_defines.svh"

// One comparison: counts it, reports a mismatch at once
`define CHK(a, b) cmp_count++; if ((a) !== (b)) begin errors++; \
   $display("ERROR t=%0t got %h exp %h", $time, (a), (b)); end

module tb_top;
   timeunit 1ns;
   timeprecision 1ps;

   // Row: register settings beside the pin results they should give
   typedef struct packed {
      logic [7:0]  sel;
      logic [7:0]  dir;
      logic [7:0]  chan;
      logic [7:0]  amp;
      logic [7:0]  cmp;
      logic [8:0]  oe;
      logic [15:0] rt;
      logic        pro;
   } apfs_row_t;

   logic        clk;
   logic        rst_n;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [17:0] paddr;
   logic [31:0] pwdata;
   logic [8:0]  pad;
   logic [8:0]  latch;
   logic [31:0] prdata_out;
   logic        pready_out;
   logic        pslverr_out;
   logic [8:0]  pad_out;
   logic [8:0]  pad_oe_n_out;
   logic [8:0]  dig_in_out;
   logic [8:0]  conv_pin_out;
   logic        conv_gain_out;
   logic        conv_ref_out;
   logic [1:0]  amp_in_out;
   logic        amp_out_pin_out;
   logic        gain_in_out;
   logic [2:0]  cmp_pos_out;
   logic        prohibited_out;
   logic [15:0] route;
   logic [31:0] rd;
   logic        er;
   apfs_row_t   r;
   int          errors = 0;
   int          cmp_count = 0;

   // Routing outputs packed to match the rt field of a row
   assign route = {cmp_pos_out, gain_in_out, amp_out_pin_out,
                   amp_in_out, conv_pin_out};

   // sel, dir, chan, amp, cmp, oe_n, route, prohibited
   apfs_row_t rows [14] = '{
      '{8'hFF, 8'h00, 8'h08, 8'h00, 8'h00, 9'h100, 16'h0100, 1'b0},
      '{8'hFF, 8'hFF, 8'h08, 8'h00, 8'h00, 9'h1FF, 16'h0100, 1'b0},
      '{8'h00, 8'hFF, 8'h03, 8'h00, 8'h00, 9'h1FF, 16'h0008, 1'b0},
      '{8'h00, 8'hFF, 8'h05, 8'h00, 8'h00, 9'h1FF, 16'h0020, 1'b0},
      '{8'h00, 8'hFF, 8'h02, 8'h80, 8'h00, 9'h1FF, 16'h0E04, 1'b0},
      '{8'h00, 8'hFF, 8'h40, 8'h40, 8'h00, 9'h1FF, 16'h1000, 1'b0},
      '{8'h00, 8'hFF, 8'h01, 8'hC0, 8'h00, 9'h1FF, 16'h1E02, 1'b0},
      '{8'h00, 8'hFF, 8'h0F, 8'h00, 8'h07, 9'h1FF, 16'hE000, 1'b0},
      '{8'h00, 8'hFF, 8'h0F, 8'h00, 8'h01, 9'h1FF, 16'h2000, 1'b0},
      '{8'h00, 8'hFF, 8'h80, 8'h00, 8'h00, 9'h1FF, 16'h0000, 1'b0},
      '{8'h04, 8'hFB, 8'h0F, 8'h00, 8'h00, 9'h1FB, 16'h0000, 1'b0},
      '{8'h01, 8'hFF, 8'h00, 8'h00, 8'h00, 9'h1FF, 16'h0000, 1'b1},
      '{8'h00, 8'hFE, 8'h0F, 8'h00, 8'h00, 9'h1FF, 16'h0000, 1'b1},
      '{8'h02, 8'hFF, 8'h0F, 8'h80, 8'h00, 9'h1FF, 16'h0000, 1'b1}
   };

   apfs_pin_mux i_apfs_pin_mux (
      .core_clk_in     (clk),
      .resetn_in       (rst_n),
      .psel_in         (psel),
      .penable_in      (penable),
      .pwrite_in       (pwrite),
      .paddr_in        (paddr),
      .pwdata_in       (pwdata),
      .pstrb_in        (4'hF),
      .prdata_out      (prdata_out),
      .pready_out      (pready_out),
      .pslverr_out     (pslverr_out),
      .pad_in          (pad),
      .out_latch_in    (latch),
      .pad_out         (pad_out),
      .pad_oe_n_out    (pad_oe_n_out),
      .dig_in_out      (dig_in_out),
      .conv_pin_out    (conv_pin_out),
      .conv_gain_out   (conv_gain_out),
      .conv_ref_out    (conv_ref_out),
      .amp_in_out      (amp_in_out),
      .amp_out_pin_out (amp_out_pin_out),
      .gain_in_out     (gain_in_out),
      .cmp_pos_out     (cmp_pos_out),
      .prohibited_out  (prohibited_out)
   );

   // Clock, 8 ns period
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   // One APB transfer; waits for pready under a bounded count
   task automatic apb(input logic wr, input logic [15:0] idx,
                      input logic [31:0] wd);
      int n;
      n = 0;
      @(posedge clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= {idx, 2'b00};
      pwdata  <= wd;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready_out !== 1'b1 && n < 20);
      if (n >= 20) errors++;
      rd = prdata_out;
      er = pslverr_out;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   // Verdict and end of run
   task automatic summarize();
      $display("comparisons %0d mismatches %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   // Watchdog: far beyond the few hundred cycles the tests need
   initial begin
      #(8 * 20000);
      errors++;
      summarize();
   end

   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      rst_n = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = '0;
      pwdata = '0;
      pad = 9'h0F5;
      latch = 9'h155;
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      // Table rows; latch flips per row, analog results must not move
      for (int i = 0; i < 14; i++) begin
         r = rows[i];
         latch <= i[0] ? 9'h0AA : 9'h155;
         apb(1'b1, `APFS_IDX_SEL_LO, {24'h0, r.sel});
         apb(1'b1, `APFS_IDX_DIR2, {24'h0, r.dir});
         apb(1'b1, `APFS_IDX_CHAN, {24'h0, r.chan});
         apb(1'b1, `APFS_IDX_AMP_CTRL, {24'h0, r.amp});
         apb(1'b1, `APFS_IDX_CMP_EN, {24'h0, r.cmp});
         // Pad sync needs three edges; four covers every output
         repeat (4) @(posedge clk);
         `CHK(pad_oe_n_out, r.oe)
         `CHK(prohibited_out, r.pro)
         if (!r.pro) begin
            `CHK(route, r.rt)
            `CHK(conv_gain_out, r.chan[6] & r.amp[6])
            `CHK(conv_ref_out, r.chan[7])
            `CHK(pad_out, latch & ~r.oe)
            `CHK(dig_in_out, pad & {1'b0, r.sel & r.dir})
         end
         $display("row %0d done", i);
      end
      // Second reset in mid-run: every pin back to input mode
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      `CHK(pad_oe_n_out, 9'h1FF)
      rst_n <= 1'b1;
      apb(1'b0, `APFS_IDX_DIR2, 32'h0);
      `CHK(rd, 32'h0000_00FF)
      apb(1'b0, `APFS_IDX_DIR7, 32'h0);
      `CHK(rd, 32'h0000_00FF)
      $display("test reset done");
      // Byte write, then clear bit 0 and set bit 6 alone
      apb(1'b1, `APFS_IDX_DIR2, 32'h0000_00A5);
      apb(1'b1, `APFS_IDX_DIR2, 32'h0001_0000);
      apb(1'b1, `APFS_IDX_DIR2, 32'h0001_0601);
      apb(1'b0, `APFS_IDX_DIR2, 32'h0);
      `CHK(rd, 32'h0000_00E4)
      $display("test bit write done");
      // Port 7 pin as digital output; absent bits keep reading one
      latch <= 9'h155;
      apb(1'b1, `APFS_IDX_DIR2, 32'h0000_00FF);
      apb(1'b1, `APFS_IDX_SEL_HI, 32'h0000_0001);
      apb(1'b1, `APFS_IDX_DIR7, 32'h0000_0000);
      apb(1'b0, `APFS_IDX_DIR7, 32'h0);
      `CHK(rd, 32'h0000_00FE)
      repeat (2) @(posedge clk);
      `CHK(pad_oe_n_out[8], 1'b0)
      `CHK(pad_out[8], latch[8])
      $display("test port7 done");
      // Unmapped place answers with an error and no data
      apb(1'b0, 16'h0100, 32'h0);
      `CHK(er, 1'b1)
      `CHK(rd, 32'h0)
      $display("test unmapped done");
      summarize();
   end
endmodule
